// File: rtl/slc_regs.vh
/*
 * Constants for the line supervision controller: timing counts at a
 * 10 MHz system clock, reset values and state codes.
 * Assumes it is included by bare name from rtl/ files only.
 */
`ifndef SLC_REGS_VH
`define SLC_REGS_VH

// ==========================================================
// Clock and timing
`define SLC_CLK_HZ 10000000
`define SLC_PWRUP_MS 100
`define SLC_UNBAL_S 5
`define SLC_POLL_S 5
`define SLC_WAKE_MS 80
`define SLC_SAMPLE_US 1000
`define SLC_PWRUP_CYC (`SLC_CLK_HZ / 1000 * `SLC_PWRUP_MS)
`define SLC_UNBAL_CYC (`SLC_CLK_HZ * `SLC_UNBAL_S)
`define SLC_POLL_CYC (`SLC_CLK_HZ * `SLC_POLL_S)
`define SLC_WAKE_CYC (`SLC_CLK_HZ / 1000 * `SLC_WAKE_MS)
`define SLC_SAMPLE_CYC (`SLC_CLK_HZ / 1000000 * `SLC_SAMPLE_US)

// ==========================================================
// Widths and reset values
`define SLC_CNT_W 27
`define SLC_DB_W 8
`define SLC_DB_DEF 8'h14
`define SLC_CNT_ZERO 27'h0000000
`define SLC_DB_ZERO 8'h00
`define SLC_DB_ONE 8'h01

// ==========================================================
// One-hot controller states
`define SLC_ST_W 5
`define SLC_ST_PWRUP 5'h01
`define SLC_ST_RUN 5'h02
`define SLC_ST_DOWN 5'h04
`define SLC_ST_WAKE 5'h08
`define SLC_ST_IDLE 5'h10

`endif

// File: rtl/slc_debounce.v
/*
 * Hook-state debouncer: a three-stage synchroniser followed by a
 * stability filter counted in sample ticks.
 * Assumes a free-running sys_clk and a one-cycle sample tick.
 */
`timescale 1ns/1ps
`include "slc_regs.vh"

module slc_debounce (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Raw pin and filter setup
  input wire raw_in,
  input wire sample_tick,
  input wire [`SLC_DB_W-1:0] stable_cnt,
  // Filtered level
  output reg level_q
);

  reg s1_q;
  reg s2_q;
  reg s3_q;
  reg [`SLC_DB_W-1:0] run_q;

  // ==========================================================
  // Synchroniser; s1_q is read only by s2_q
  always @(posedge sys_clk) begin
    if (!nrst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // Accept a change only after it held for stable_cnt samples
  always @(posedge sys_clk) begin
    if (!nrst) begin
      run_q <= `SLC_DB_ZERO;
      level_q <= 1'b0;
    end else if (s2_q != s3_q || s3_q == level_q) begin
      run_q <= `SLC_DB_ZERO; // Any bounce restarts the count
    end else if (sample_tick) begin
      if (run_q + `SLC_DB_ONE >= stable_cnt) begin
        level_q <= s3_q;
        run_q <= `SLC_DB_ZERO;
      end else begin
        run_q <= run_q + `SLC_DB_ONE;
      end
    end
  end

endmodule // slc_debounce

// File: rtl/slc_ctrl.v
/*
 * Local controller for a subscriber line interface: power-up
 * sequencing, hook debounce, unbalance watchdog with power-down and
 * polling, ringing and line reversal control.
 * Assumes device pins arrive asynchronously and user orders come
 * from logic on sys_clk.
 */
`timescale 1ns/1ps
`include "slc_regs.vh"

// Overview of operation
// - Dial breaks pulse hook low; controller debounces
// - Unbalance held over 5 s forces power down
// - After unbalance power down, poll every 5 s
// - Unbalance flag masked while ringing is on
// - Controller drops ringing input after trip
// - Reverse input low except when reversal wanted
// - Off-hook wakes from idle power down; mask 80 ms break
module slc_ctrl #(
  parameter [`SLC_CNT_W-1:0] PWRUP_CYC = `SLC_PWRUP_CYC,
  parameter [`SLC_CNT_W-1:0] UNBAL_CYC = `SLC_UNBAL_CYC,
  parameter [`SLC_CNT_W-1:0] POLL_CYC = `SLC_POLL_CYC,
  parameter [`SLC_CNT_W-1:0] WAKE_CYC = `SLC_WAKE_CYC,
  parameter [`SLC_CNT_W-1:0] SAMPLE_CYC = `SLC_SAMPLE_CYC
) (
  // Clock and reset
  input wire sys_clk,
  input wire nrst,
  // Device indications
  input wire hook_state_out,
  input wire unbalance_flag,
  // Device controls
  output reg power_down_in,
  output reg ringing_control_in,
  output reg line_reverse_in,
  // User orders
  input wire usr_ring_req,
  input wire usr_reverse_req,
  input wire usr_idle_req,
  input wire [`SLC_DB_W-1:0] usr_db_samples,
  // User status
  output reg usr_off_hook_q,
  output reg usr_trip_q,
  output reg usr_unbal_fault_q,
  output wire usr_ready
);

  reg [`SLC_ST_W-1:0] state_q;
  reg [`SLC_CNT_W-1:0] tmr_q;
  reg [`SLC_CNT_W-1:0] ub_cnt_q;
  reg [`SLC_CNT_W-1:0] smp_q;
  reg ub1_q;
  reg ub2_q;
  reg ub3_q;
  reg ub_lvl_q;
  reg off_hook_prev_q;
  wire hook_db;
  wire sample_tick;
  wire st_run;
  wire st_wake;

  // State decode by full code, not by a bare bit position
  assign sample_tick = (smp_q == `SLC_CNT_ZERO);
  assign st_run = (state_q == `SLC_ST_RUN);
  assign st_wake = (state_q == `SLC_ST_WAKE);
  assign usr_ready = st_run;

  // ==========================================================
  // Debounce sample timebase
  always @(posedge sys_clk) begin
    if (!nrst) begin
      smp_q <= `SLC_CNT_ZERO;
    end else if (sample_tick) begin
      smp_q <= SAMPLE_CYC - 27'h0000001;
    end else begin
      smp_q <= smp_q - 27'h0000001;
    end
  end

  // ==========================================================
  // Hook debouncer; zero setting is treated as one sample
  slc_debounce u_db (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .raw_in(hook_state_out),
    .sample_tick(sample_tick),
    .stable_cnt(usr_db_samples),
    .level_q(hook_db)
  );

  // ==========================================================
  // Unbalance synchroniser, agreeing stages decide the level
  always @(posedge sys_clk) begin
    if (!nrst) begin
      ub1_q <= 1'b0;
      ub2_q <= 1'b0;
      ub3_q <= 1'b0;
      ub_lvl_q <= 1'b0;
    end else begin
      ub1_q <= unbalance_flag;
      ub2_q <= ub1_q;
      ub3_q <= ub2_q;
      if (ub2_q == ub3_q) begin
        ub_lvl_q <= ub3_q;
      end
    end
  end

  // ==========================================================
  // Unbalance duration counter; ringing masks and clears it.
  // The wake window is normal feed too, so it keeps counting there.
  always @(posedge sys_clk) begin
    if (!nrst) begin
      ub_cnt_q <= `SLC_CNT_ZERO;
    end else if (!ub_lvl_q || ringing_control_in ||
        !(st_run || st_wake)) begin
      ub_cnt_q <= `SLC_CNT_ZERO;
    end else if (ub_cnt_q != UNBAL_CYC) begin
      ub_cnt_q <= ub_cnt_q + 27'h0000001;
    end
  end

  // ==========================================================
  // Main sequencer: power-up, run, fault poll, idle, wake
  always @(posedge sys_clk) begin
    if (!nrst) begin
      state_q <= `SLC_ST_PWRUP;
      tmr_q <= `SLC_CNT_ZERO;
      power_down_in <= 1'b1;
      usr_unbal_fault_q <= 1'b0;
    end else begin
      case (state_q)
        `SLC_ST_PWRUP: begin
          power_down_in <= 1'b1;
          if (tmr_q + 27'h0000001 >= PWRUP_CYC) begin
            tmr_q <= `SLC_CNT_ZERO;
            power_down_in <= 1'b0;
            state_q <= `SLC_ST_RUN;
          end else begin
            tmr_q <= tmr_q + 27'h0000001;
          end
        end
        `SLC_ST_RUN: begin
          tmr_q <= `SLC_CNT_ZERO;
          if (ub_cnt_q == UNBAL_CYC) begin
            power_down_in <= 1'b1;
            usr_unbal_fault_q <= 1'b1;
            state_q <= `SLC_ST_DOWN;
          end else if (usr_idle_req && !hook_db) begin
            power_down_in <= 1'b1; // Save power while on hook
            state_q <= `SLC_ST_IDLE;
          end
        end
        `SLC_ST_DOWN: begin
          // Poll: after each period try normal operation again
          if (tmr_q + 27'h0000001 >= POLL_CYC) begin
            tmr_q <= `SLC_CNT_ZERO;
            power_down_in <= 1'b0;
            usr_unbal_fault_q <= 1'b0;
            state_q <= `SLC_ST_RUN;
          end else begin
            tmr_q <= tmr_q + 27'h0000001;
          end
        end
        `SLC_ST_IDLE: begin
          tmr_q <= `SLC_CNT_ZERO;
          if (hook_db || !usr_idle_req) begin
            power_down_in <= 1'b0;
            state_q <= `SLC_ST_WAKE;
          end
        end
        `SLC_ST_WAKE: begin
          // Hook status forced off-hook here so the power-up break is hidden;
          // the debounced hook lags the pin, so wait for it to return,
          // but at most two windows so an on-hook wake cannot stall
          if (tmr_q + 27'h0000001 >= WAKE_CYC &&
              (hook_db || tmr_q >= WAKE_CYC + WAKE_CYC)) begin
            tmr_q <= `SLC_CNT_ZERO;
            state_q <= `SLC_ST_RUN;
          end else begin
            tmr_q <= tmr_q + 27'h0000001;
          end
        end
        default: begin
          state_q <= `SLC_ST_PWRUP;
          tmr_q <= `SLC_CNT_ZERO;
          power_down_in <= 1'b1;
        end
      endcase
    end
  end

  // ==========================================================
  // Hook status to user, forced off-hook through the wake mask window
  always @(posedge sys_clk) begin
    if (!nrst) begin
      usr_off_hook_q <= 1'b0;
      off_hook_prev_q <= 1'b0;
    end else begin
      off_hook_prev_q <= hook_db;
      if (st_wake) begin
        usr_off_hook_q <= 1'b1;
      end else if (st_run) begin
        usr_off_hook_q <= hook_db;
      end
    end
  end

  // ==========================================================
  // Ringing and reversal drive; trip drops ringing ourselves
  always @(posedge sys_clk) begin
    if (!nrst) begin
      ringing_control_in <= 1'b0;
      line_reverse_in <= 1'b0;
      usr_trip_q <= 1'b0;
    end else begin
      line_reverse_in <= usr_reverse_req && st_run;
      if (!st_run || !usr_ring_req) begin
        ringing_control_in <= 1'b0;
        if (!usr_ring_req) begin
          usr_trip_q <= 1'b0;
        end
      end else if (ringing_control_in && hook_db && !off_hook_prev_q) begin
        ringing_control_in <= 1'b0;
        usr_trip_q <= 1'b1;
      end else if (!usr_trip_q && !hook_db) begin
        ringing_control_in <= 1'b1;
      end
    end
  end

endmodule // slc_ctrl

// File: sim/slc_ctrl_asserts.sv
/* Port checker for the line supervision controller.
   Assumes a bind onto slc_ctrl with its timing parameters. */
`timescale 1ns/1ps
module slc_ctrl_asserts #(
  parameter PWRUP_CYC = 100,
  parameter UNBAL_CYC = 500,
  parameter POLL_CYC = 500,
  parameter SAMPLE_CYC = 10
) (
  // Clock, reset and device pins
  input wire sys_clk,
  input wire nrst,
  input wire hook_state_out,
  input wire unbalance_flag,
  input wire power_down_in,
  input wire ringing_control_in,
  input wire line_reverse_in,
  // User side
  input wire usr_reverse_req,
  input wire [7:0] usr_db_samples,
  input wire usr_off_hook_q,
  input wire usr_trip_q,
  input wire usr_unbal_fault_q
);
  // ====
  // Counters: long counts cannot be unrolled as repetitions
  integer up_n, unb_n, pd_n, hk_n;
  always @(posedge sys_clk) begin
    if (!nrst) begin
      up_n <= 0;
      unb_n <= 0;
      pd_n <= 0;
      hk_n <= 0;
    end else begin
      up_n <= up_n + 1;
      unb_n <= (unbalance_flag && !ringing_control_in && !power_down_in)
        ? unb_n + 1 : 0;
      pd_n <= usr_unbal_fault_q ? pd_n + 1 : 0;
      hk_n <= hook_state_out ? hk_n + 1 : 0;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  AST_PWRUP: assert property (up_n < PWRUP_CYC - 1 |-> power_down_in)
    else $error("pwrup");
  AST_PWRUP_END: assert property (up_n == PWRUP_CYC |->
    !power_down_in) else $error("pwrup end");
  AST_UNB_TIME: assert property ($rose(usr_unbal_fault_q) |->
    unb_n >= UNBAL_CYC - 1) else $error("unb early");
  AST_UNB_LATE: assert property (unb_n <= UNBAL_CYC + 10)
    else $error("unb late");
  AST_POLL: assert property ($fell(usr_unbal_fault_q) |->
    !power_down_in && pd_n >= POLL_CYC - 1 && pd_n <= POLL_CYC + 1)
    else $error("poll");
  AST_TRIP_DROP: assert property (usr_trip_q |->
    !ringing_control_in) else $error("trip");
  AST_TRIP_WHY: assert property ($rose(usr_trip_q) |->
    usr_off_hook_q) else $error("trip cause");
  AST_REV_LOW: assert property (!usr_reverse_req [*2] |->
    !line_reverse_in) else $error("rev");
  // The forced report of the wake window rises one cycle after the
  // power-down pin falls; it is not a debounced edge
  AST_DEBOUNCE: assert property ($rose(usr_off_hook_q) &&
    !$past(power_down_in, 2) |->
    hk_n + SAMPLE_CYC >= usr_db_samples * SAMPLE_CYC)
    else $error("debounce");
  // Wake only: not the end of power-up nor the end of a fault poll
  AST_WAKE: assert property ($fell(power_down_in) &&
    !$past(usr_unbal_fault_q) && up_n > PWRUP_CYC |=>
    usr_off_hook_q [*8]) else $error("wake");
endmodule // slc_ctrl_asserts

bind slc_ctrl slc_ctrl_asserts #(.PWRUP_CYC(PWRUP_CYC),
  .UNBAL_CYC(UNBAL_CYC), .POLL_CYC(POLL_CYC), .SAMPLE_CYC(SAMPLE_CYC))
  slc_ctrl_asserts_i (.sys_clk, .nrst, .hook_state_out, .unbalance_flag,
  .power_down_in, .ringing_control_in, .line_reverse_in, .usr_reverse_req,
  .usr_db_samples, .usr_off_hook_q, .usr_trip_q, .usr_unbal_fault_q);

// File: sim/slc_line_model.sv
/* Behavioural model of the line interface device pins.
   Assumes the bench sets the phone state and lead offset. */
`timescale 1ns/1ps
module slc_line_model (
  // Controls
  input wire power_down_in,
  input wire ringing_control_in,
  input wire line_reverse_in,
  // Line set by the bench
  input wire phone_off,
  input wire lead_offset,
  // Indications
  output wire hook_state_out,
  output wire unbalance_flag,
  output wire ring_on,
  output wire reversed
);
  reg brk_q = 1'b0;
  reg trip_q = 1'b0;
  // ====
  // Hook seen in power down and through ringing, no glitch on ring edges
  assign hook_state_out = phone_off && !brk_q;
  // Loop current needs time after wake, so the hook pin breaks for
  // about one wake window, longer than the bench's debounce time
  always @(negedge power_down_in) begin
    if (phone_off) begin
      brk_q = 1'b1;
      #8000;
      brk_q = 1'b0;
    end
  end
  // Trip holds until ringing control is dropped
  always @(phone_off or ringing_control_in) begin
    if (!ringing_control_in)
      trip_q = 1'b0;
    else if (phone_off)
      trip_q = 1'b1;
  end
  assign ring_on = ringing_control_in && !trip_q && !power_down_in;
  assign reversed = line_reverse_in && !power_down_in;
  assign unbalance_flag = lead_offset;
endmodule // slc_line_model

// File: sim/slc_ctrl_tb.sv
/* Testbench for slc_ctrl against the device pin model.
   Assumes shortened timing counts set at the instance. */
`timescale 1ns/1ps
module slc_ctrl_tb;
  localparam PU = 100, UB = 500, PL = 500, WK = 80, SP = 10;
  reg sys_clk = 1'b0;
  reg nrst = 1'b0;
  reg ring = 1'b0, rev_r = 1'b0, idle = 1'b0, phone = 1'b0, offs = 1'b0;
  reg [7:0] dbs = 8'h04;
  wire hk, ub, pd, rc, lr, off_q, trip_q, flt_q, rdy, ring_on, rev;
  integer n_fail = 0, comparisons = 0, cyc = 0;
  // ====
  // Design and device model
  slc_ctrl #(.PWRUP_CYC(PU), .UNBAL_CYC(UB), .POLL_CYC(PL), .WAKE_CYC(WK),
    .SAMPLE_CYC(SP)) slc_ctrl_i (.sys_clk(sys_clk), .nrst(nrst),
    .hook_state_out(hk), .unbalance_flag(ub), .power_down_in(pd),
    .ringing_control_in(rc), .line_reverse_in(lr), .usr_ring_req(ring),
    .usr_reverse_req(rev_r), .usr_idle_req(idle), .usr_db_samples(dbs),
    .usr_off_hook_q(off_q), .usr_trip_q(trip_q), .usr_unbal_fault_q(flt_q),
    .usr_ready(rdy));
  slc_line_model slc_line_model_i (.power_down_in(pd),
    .ringing_control_in(rc), .line_reverse_in(lr), .phone_off(phone),
    .lead_offset(offs), .hook_state_out(hk), .unbalance_flag(ub),
    .ring_on(ring_on), .reversed(rev));
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  // Hang guard, well above the few thousand cycles the tests need
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      results;
    end
  end
  task tick(input integer n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task chk(input [63:0] name, input exp, input got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("MISMATCH %0s exp %b got %b", name, exp, got);
    end
  endtask
  function pick(input integer s);
    case (s)
      0: pick = rdy;
      1: pick = trip_q;
      2: pick = flt_q;
      3: pick = pd;
      default: pick = off_q;
    endcase
  endfunction
  task wait_for(input integer s, input v, input integer lim);
    integer k;
    k = 0;
    while (pick(s) !== v && k < lim) begin
      tick(1);
      k = k + 1;
    end
  endtask
  task results;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    tick(6);
    nrst = 1'b1;
    tick(2);
    chk("pwrup", 1'b1, pd);
    chk("notrdy", 1'b0, rdy);
    wait_for(0, 1'b1, PU + 10);
    chk("ready", 1'b0, pd);
    chk("rdy", 1'b1, rdy);
    rev_r = 1'b1;
    tick(2);
    chk("rev", 1'b1, rev);
    chk("revpin", 1'b1, lr);
    rev_r = 1'b0;
    tick(2);
    chk("norev", 1'b0, lr);
    ring = 1'b1;
    tick(2);
    chk("ring", 1'b1, ring_on);
    phone = 1'b1;
    tick(1);
    chk("devtrip", 1'b0, ring_on);
    wait_for(1, 1'b1, 6 * SP + 10);
    chk("trip", 1'b1, trip_q);
    chk("rcdrop", 1'b0, rc);
    chk("offhk", 1'b1, off_q);
    ring = 1'b0;
    tick(2);
    chk("tripclr", 1'b0, trip_q);
    // Short dial break filtered at 4 samples, caught at 1 sample
    phone = 1'b0;
    tick(2 * SP);
    phone = 1'b1;
    tick(6 * SP);
    chk("dialbrk", 1'b1, off_q);
    dbs = 8'h01;
    phone = 1'b0;
    tick(2 * SP);
    chk("dialone", 1'b0, off_q);
    phone = 1'b1;
    tick(6 * SP);
    chk("dialend", 1'b1, off_q);
    dbs = 8'h04;
    phone = 1'b0;
    wait_for(4, 1'b0, 6 * SP + 10);
    chk("onhk", 1'b0, off_q);
    ring = 1'b1;
    offs = 1'b1;
    tick(UB + 50);
    chk("masked", 1'b0, flt_q);
    ring = 1'b0;
    wait_for(2, 1'b1, UB + 20);
    chk("unbpd", 1'b1, pd);
    wait_for(2, 1'b0, PL + 10);
    chk("poll", 1'b0, pd);
    chk("pollflt", 1'b0, flt_q);
    offs = 1'b0;
    idle = 1'b1;
    wait_for(3, 1'b1, 10);
    chk("idle", 1'b1, pd);
    chk("idlerdy", 1'b0, rdy);
    // Wake by off-hook; the pin break outlasts the debounce time
    phone = 1'b1;
    wait_for(3, 1'b0, 8 * SP);
    tick(WK / 8);
    chk("brkmask", 1'b1, off_q);
    idle = 1'b0;
    tick(WK);
    chk("awake", 1'b1, off_q);
    tick(WK);
    chk("awake2", 1'b1, off_q);
    chk("rdy2", 1'b1, rdy);
    results;
  end
endmodule // slc_ctrl_tb
